// *** pmcc_params.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef PMCC_PARAMS_SVH
`define PMCC_PARAMS_SVH

// Register byte offsets on the APB slave
`define PMCC_OFF_MODE     8'h00
`define PMCC_OFF_PWR      8'h04
`define PMCC_OFF_DIV      8'h08
`define PMCC_OFF_MAP      8'h0C
`define PMCC_OFF_EFLAG    8'h10
`define PMCC_OFF_ECFG     8'h14
`define PMCC_OFF_PINSEL   8'h18
`define PMCC_OFF_PLL      8'h1C
`define PMCC_OFF_STAT     8'h20

// Mode register bit positions
`define PMCC_MODE_IDLE    0
`define PMCC_MODE_PDOWN   1

// PLL control bit positions
`define PMCC_PLL_EN       0
`define PMCC_PLL_CONN     1

// Divider codes: reset code selects a quarter rate
`define PMCC_DIV_QUARTER  2'h0
`define PMCC_DIV_FULL     2'h1
`define PMCC_DIV_HALF     2'h2

// Divider terminal counts for each rate
`define PMCC_LAST_FULL    2'h0
`define PMCC_LAST_HALF    2'h1
`define PMCC_LAST_QUARTER 2'h3

// Event config field positions inside the config word
`define PMCC_ECFG_EDGE_LSB 0
`define PMCC_ECFG_POL_LSB  4
`define PMCC_ECFG_WAKE_LSB 8

// Oscillator settle count after the oscillator reports running
`define PMCC_WAKE_CLKS    4096

`endif

// *** pmcc_pkg.sv ***
// Types shared by the power mode and clock control block
package pmcc_pkg;

  // Control state, one-hot
  typedef enum logic [4:0] {
    PMCC_ST_RST   = 5'b00001,  // Internal reset held
    PMCC_ST_WAKE  = 5'b00010,  // Settling after deep sleep
    PMCC_ST_RUN   = 5'b00100,  // Normal execution
    PMCC_ST_IDLE  = 5'b01000,  // Light sleep
    PMCC_ST_PDOWN = 5'b10000   // Deep sleep
  } pmcc_state_e;

  // External interrupt channel configuration
  typedef struct packed {
    logic [3:0] wake;       // Channel may end deep sleep
    logic [3:0] pol;        // 1: high level or rising edge
    logic [3:0] edge_mode;  // 1: edge, 0: level
  } pmcc_ecfg_s;

endpackage

// *** pmcc_top.sv ***
// Power mode, wake-up timer, clock divider and remap control
//
// How it works
// - Light sleep halts execution until reset/interrupt
// - Peripherals keep clocks and interrupts in light sleep
// - Deep sleep stops the crystal oscillator
// - Deep sleep retains state and holds pins
// - Deep sleep ends only on reset/clockless interrupt
// - Nine pins combine into four interrupt channels
// - Enabled external interrupt wakes from deep sleep
// - Map control selects flash or RAM vectors
// - Each peripheral can be powered off alone
// - Bus clock is full, half or quarter rate
// - Divider resets to quarter rate
// - PLL keeps running through light sleep
// - Wake timer checks oscillator before execution
// - Reset held until oscillator, count, flash ready
// - Every deep sleep exit passes the wake timer
// - PLL off and bypassed after reset
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "pmcc_params.svh"

module pmcc_top #(
  parameter int NPERIPH   = 8,                // Gated peripherals
  parameter int WAKE_CLKS = `PMCC_WAKE_CLKS   // Settle count
) (
  input  wire logic               clk_sys_i,        // Processor clock
  input  wire logic               resetn_i,         // Sync, active low
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic [8:0]         eint_pin_i,       // External int pins
  input  wire logic               periph_irq_i,     // Other interrupts
  input  wire logic               osc_ready_i,      // Oscillator running
  input  wire logic               flash_done_i,     // Flash init done
  input  wire logic               pll_lock_i,       // PLL locked
  output logic                    cpu_reset_n_o,    // Internal reset
  output logic                    cpu_run_o,        // Processor clock on
  output logic                    osc_enable_o,     // Oscillator on
  output logic                    pll_enable_o,     // PLL powered
  output logic                    pll_connect_o,    // PLL drives clock
  output logic                    pclk_en_o,        // Bus clock enable
  output logic [NPERIPH-1:0]      periph_pwr_o,     // Per-periph power
  output logic                    map_sram_o,       // Vectors from RAM
  output logic                    hold_pins_o,      // Freeze pin levels
  output logic [3:0]              eint_irq_o        // Channel flags
);

  // Combined active level of one channel from its pins
  function automatic logic chan_level(input logic [8:0] pins,
                                      input logic [8:0] sel,
                                      input logic       pol,
                                      input int         ch);
    logic acc;
    acc = 1'b0;
    for (int i = ch; i < 9; i += 4) begin
      acc = acc | (sel[i] & (pins[i] ~^ pol));
    end
    return acc;
  endfunction

  // Terminal count for a divider code; reserved code acts as quarter
  function automatic logic [1:0] div_last(input logic [1:0] code);
    return (code == `PMCC_DIV_FULL) ? `PMCC_LAST_FULL :
           (code == `PMCC_DIV_HALF) ? `PMCC_LAST_HALF :
                                      `PMCC_LAST_QUARTER;
  endfunction

  // Registers
  pmcc_pkg::pmcc_state_e  state_q, state_d;  // Control state
  logic [1:0]             mode_q;            // Sleep request bits
  logic [NPERIPH-1:0]     pwr_q;             // Peripheral power
  logic [1:0]             div_q;             // Programmed divider
  logic [1:0]             act_last_q;        // Divider in force
  logic [1:0]             div_cnt_q;         // Divider phase
  logic                   map_q;             // Vector map select
  logic [3:0]             eflag_q;           // Sticky channel flags
  logic [3:0]             elvl_q;            // Previous channel levels
  pmcc_pkg::pmcc_ecfg_s   ecfg_q;            // Channel config
  logic [8:0]             pinsel_q;          // Pin function select
  logic [1:0]             pll_q;             // PLL enable, connect
  logic [12:0]            wcnt_q;            // Wake timer count
  logic [31:0]            prdata_q;
  logic                   pready_q;
  logic                   pslverr_q;
  logic                   pclk_q;
  logic                   run_q;
  logic                   rstn_q;
  logic                   osc_q;
  logic                   hold_q;

  // Bus decode
  wire access_w  = psel_i & penable_i;
  wire done_w    = access_w & pready_q;   // Transfer completes
  wire wr_w      = done_w & pwrite_i;
  wire hit_mode  = paddr_i == `PMCC_OFF_MODE;
  wire hit_pwr   = paddr_i == `PMCC_OFF_PWR;
  wire hit_div   = paddr_i == `PMCC_OFF_DIV;
  wire hit_map   = paddr_i == `PMCC_OFF_MAP;
  wire hit_eflag = paddr_i == `PMCC_OFF_EFLAG;
  wire hit_ecfg  = paddr_i == `PMCC_OFF_ECFG;
  wire hit_psel  = paddr_i == `PMCC_OFF_PINSEL;
  wire hit_pll   = paddr_i == `PMCC_OFF_PLL;
  wire hit_stat  = paddr_i == `PMCC_OFF_STAT;
  wire mapped_w  = hit_mode | hit_pwr | hit_div | hit_map | hit_eflag |
                   hit_ecfg | hit_psel | hit_pll | hit_stat;

  // Read data selection, unused bits read as zero
  wire [31:0] rd_w =
    hit_mode  ? {30'h0000_0000, mode_q} :
    hit_pwr   ? 32'(pwr_q) :
    hit_div   ? {30'h0000_0000, div_q} :
    hit_map   ? {31'h0000_0000, map_q} :
    hit_eflag ? {28'h000_0000, eflag_q} :
    hit_ecfg  ? {20'h0_0000, ecfg_q} :
    hit_psel  ? {23'h00_0000, pinsel_q} :
    hit_pll   ? {29'h0000_0000, pll_lock_i, pll_q} :
    hit_stat  ? {26'h000_0000, osc_ready_i, state_q} :
                32'h0000_0000;

  // Channel levels from pins, polarity applied
  logic [3:0] lvl_w;
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      lvl_w[c] = chan_level(eint_pin_i, pinsel_q, ecfg_q.pol[c], c);
    end
  end

  // Edge channels flag on a new active level, level channels flag while it is active
  wire [3:0] eset_w  = (ecfg_q.edge_mode & lvl_w & ~elvl_q) |
                       (~ecfg_q.edge_mode & lvl_w);
  wire [3:0] eclr_w  = (wr_w & hit_eflag) ? pwdata_i[3:0] : 4'h0;
  // Deep sleep wake is sensed from pin levels with no clock needed
  wire       pd_wake = |(lvl_w & ecfg_q.wake);
  wire       irq_any = (|eflag_q) | periph_irq_i;
  wire       wtimer_done = wcnt_q == 13'(WAKE_CLKS - 1);
  wire [1:0] div_nxt = (div_cnt_q == act_last_q) ? 2'h0 :
                       2'(div_cnt_q + 2'h1);

  // Next control state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pmcc_pkg::PMCC_ST_RST: begin
        // Leave reset only with oscillator, count and flash ready
        if (osc_ready_i && wtimer_done && flash_done_i) begin
          state_d = pmcc_pkg::PMCC_ST_RUN;
        end
      end
      pmcc_pkg::PMCC_ST_WAKE: begin
        if (osc_ready_i && wtimer_done) begin
          state_d = pmcc_pkg::PMCC_ST_RUN;
        end
      end
      pmcc_pkg::PMCC_ST_RUN: begin
        // Deep sleep has priority if both bits are set
        if (mode_q[`PMCC_MODE_PDOWN]) begin
          state_d = pmcc_pkg::PMCC_ST_PDOWN;
        end else if (mode_q[`PMCC_MODE_IDLE]) begin
          state_d = pmcc_pkg::PMCC_ST_IDLE;
        end
      end
      pmcc_pkg::PMCC_ST_IDLE: begin
        if (irq_any) begin
          state_d = pmcc_pkg::PMCC_ST_RUN;
        end
      end
      pmcc_pkg::PMCC_ST_PDOWN: begin
        if (pd_wake) begin
          state_d = pmcc_pkg::PMCC_ST_WAKE;
        end
      end
      default: state_d = pmcc_pkg::PMCC_ST_RST;
    endcase
  end

  // State and wake timer; the timer only runs while oscillator is up
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_q <= pmcc_pkg::PMCC_ST_RST;
      wcnt_q  <= 13'h0000;
    end else begin
      state_q <= state_d;
      if ((state_q == pmcc_pkg::PMCC_ST_RST ||
           state_q == pmcc_pkg::PMCC_ST_WAKE) && osc_ready_i &&
          !wtimer_done) begin
        wcnt_q <= 13'(wcnt_q + 13'h0001);
      end else if (state_q != pmcc_pkg::PMCC_ST_RST &&
                   state_q != pmcc_pkg::PMCC_ST_WAKE) begin
        wcnt_q <= 13'h0000;
      end
    end
  end

  // Sleep request bits: software sets, wake clears
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mode_q <= 2'h0;
    end else if (state_q == pmcc_pkg::PMCC_ST_IDLE && irq_any) begin
      mode_q[`PMCC_MODE_IDLE] <= 1'b0;
    end else if (state_q == pmcc_pkg::PMCC_ST_PDOWN && pd_wake) begin
      mode_q[`PMCC_MODE_PDOWN] <= 1'b0;
    end else if (wr_w && hit_mode) begin
      mode_q <= pwdata_i[1:0];
    end
  end

  // Plain configuration registers; frozen in deep sleep by no clocked use
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pwr_q    <= {NPERIPH{1'b1}};
      div_q    <= `PMCC_DIV_QUARTER;
      map_q    <= 1'b0;
      ecfg_q   <= '0;
      pinsel_q <= 9'h000;
      pll_q    <= 2'h0;
    end else if (wr_w) begin
      if (hit_pwr)  pwr_q    <= pwdata_i[NPERIPH-1:0];
      if (hit_div)  div_q    <= pwdata_i[1:0];
      if (hit_map)  map_q    <= pwdata_i[0];
      if (hit_ecfg) ecfg_q   <= pwdata_i[11:0];
      if (hit_psel) pinsel_q <= pwdata_i[8:0];
      if (hit_pll)  pll_q    <= pwdata_i[1:0];
    end
  end

  // Channel flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      eflag_q <= 4'h0;
      elvl_q  <= 4'h0;
    end else begin
      eflag_q <= (eflag_q & ~eclr_w) | eset_w;
      elvl_q  <= lvl_w;
    end
  end

  // Bus divider: the new ratio is adopted only when a period ends
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      act_last_q <= `PMCC_LAST_QUARTER;
      div_cnt_q  <= 2'h0;
      pclk_q     <= 1'b0;
    end else begin
      div_cnt_q <= div_nxt;
      pclk_q    <= div_cnt_q == act_last_q;
      if (div_cnt_q == act_last_q) begin
        act_last_q <= div_last(div_q);
      end
    end
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access_w & ~pready_q;
      pslverr_q <= access_w & ~pready_q & ~mapped_w;
      prdata_q  <= (access_w & ~pready_q & ~pwrite_i) ? rd_w :
                   32'h0000_0000;
    end
  end

  // Power outputs follow the next state so they match state_q
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      run_q  <= 1'b0;
      rstn_q <= 1'b0;
      osc_q  <= 1'b1;
      hold_q <= 1'b0;
    end else begin
      run_q  <= state_d == pmcc_pkg::PMCC_ST_RUN;
      rstn_q <= state_d != pmcc_pkg::PMCC_ST_RST;
      osc_q  <= state_d != pmcc_pkg::PMCC_ST_PDOWN;
      hold_q <= state_d == pmcc_pkg::PMCC_ST_PDOWN;
    end
  end

  // Output drive; PLL follows pll_q through light sleep and deep sleep alike
  assign prdata_o      = prdata_q;
  assign pready_o      = pready_q;
  assign pslverr_o     = pslverr_q;
  assign cpu_reset_n_o = rstn_q;
  assign cpu_run_o     = run_q;
  assign osc_enable_o  = osc_q;
  assign pll_enable_o  = pll_q[`PMCC_PLL_EN];
  assign pll_connect_o = pll_q[`PMCC_PLL_CONN];
  assign pclk_en_o     = pclk_q;
  assign periph_pwr_o  = pwr_q;
  assign map_sram_o    = map_q;
  assign hold_pins_o   = hold_q;
  assign eint_irq_o    = eflag_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  AST_IDLE_HALT: assert property (
    state_q == pmcc_pkg::PMCC_ST_IDLE |-> !cpu_run_o)
    else $error("Processor runs in light sleep");
  AST_IDLE_PCLK: assert property (
    state_q == pmcc_pkg::PMCC_ST_IDLE && act_last_q == 2'h0 |->
    pclk_en_o && osc_enable_o)
    else $error("Peripheral clock stopped in light sleep");
  AST_PD_OSC: assert property (
    state_q == pmcc_pkg::PMCC_ST_PDOWN |-> !osc_enable_o && !pll_q[0] ||
    !osc_enable_o)
    else $error("Oscillator left on in deep sleep");
  AST_PD_HOLD: assert property (
    state_q == pmcc_pkg::PMCC_ST_PDOWN ##1
    state_q == pmcc_pkg::PMCC_ST_PDOWN |->
    hold_pins_o && $stable(map_sram_o) && $stable(periph_pwr_o))
    else $error("State changed in deep sleep");
  AST_PD_EXIT: assert property (
    state_q == pmcc_pkg::PMCC_ST_PDOWN && !pd_wake |=>
    state_q == pmcc_pkg::PMCC_ST_PDOWN)
    else $error("Deep sleep left without wake");
  AST_EINT_WAKE: assert property (
    state_q == pmcc_pkg::PMCC_ST_PDOWN && pd_wake |=>
    state_q == pmcc_pkg::PMCC_ST_WAKE ##1 osc_enable_o)
    else $error("Enabled interrupt did not wake");
  AST_RST_HOLD: assert property (
    $rose(cpu_reset_n_o) |->
    $past(flash_done_i) && $past(osc_ready_i) && $past(wtimer_done))
    else $error("Reset released too early");
  AST_WAKE_TIMER: assert property (
    $rose(cpu_run_o) && $past(state_q) == pmcc_pkg::PMCC_ST_WAKE |->
    $past(wtimer_done))
    else $error("Wake skipped the timer");
  AST_DIV_RESET: assert property (disable iff (1'b0)
    !resetn_i |=> act_last_q == `PMCC_LAST_QUARTER && div_q == 2'h0)
    else $error("Divider not quarter after reset");
  AST_PLL_RESET: assert property (disable iff (1'b0)
    !resetn_i |=> !pll_enable_o && !pll_connect_o)
    else $error("PLL active after reset");
  AST_DIV_QUARTER: assert property (
    pclk_en_o && act_last_q == `PMCC_LAST_QUARTER |=>
    !pclk_en_o ##1 !pclk_en_o ##1 !pclk_en_o)
    else $error("Short peripheral clock period");

  COV_IDLE_WAKE: cover property (
    state_q == pmcc_pkg::PMCC_ST_IDLE ##1
    state_q == pmcc_pkg::PMCC_ST_RUN);
  COV_PD_WAKE: cover property (
    state_q == pmcc_pkg::PMCC_ST_WAKE ##1
    state_q == pmcc_pkg::PMCC_ST_RUN);
  COV_DIV_FULL: cover property (act_last_q == `PMCC_LAST_FULL);

endmodule

// *** pmcc_top_tb.sv ***
// Self-checking bench for the power mode and clock control block
`timescale 1ns/1ps
`include "pmcc_params.svh"

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  n_errors++; $display("unexpected t=%0t got=%h exp=%h", $time, got, exp); \
  end end

module pmcc_top_tb;
  localparam int WAKE = 8;        // Short settle count keeps the run brief
  localparam int LIMIT = 20000;   // Cycle ceiling for a hung run

  logic              clk_sys_i;      // Processor clock
  logic              resetn_i;       // Sync reset, active low
  logic              psel;           // APB select
  logic              penable;        // APB access phase
  logic              pwrite;         // APB direction
  logic [7:0]        paddr;          // APB byte address
  logic [31:0]       pwdata;         // APB write data
  logic [31:0]       prdata;         // APB read data
  logic              pready;         // APB ready pulse
  logic              pslverr;        // APB error pulse
  logic [8:0]        eint_pin_i;     // External interrupt pins
  logic              periph_irq_i;   // Other peripheral interrupts
  logic              osc_ready_i;    // Oscillator running
  logic              flash_done_i;   // Flash init done
  logic              pll_lock_i;     // PLL lock status
  logic              cpu_reset_n_o;  // Internal reset
  logic              cpu_run_o;      // Processor clock on
  logic              osc_enable_o;   // Oscillator on
  logic              pll_enable_o;   // PLL powered
  logic              pll_connect_o;  // PLL drives clock
  logic              pclk_en_o;      // Bus clock enable
  logic [7:0]        periph_pwr_o;   // Peripheral power
  logic              map_sram_o;     // Vector source
  logic              hold_pins_o;    // Pin freeze
  logic [3:0]        eint_irq_o;     // Channel flags
  int                n_errors;       // Mismatches seen
  int                checks_done;    // Comparisons made
  int                cycles;         // Cycle counter for timeout
  int                per;            // Measured bus clock period
  int                k;              // Loop index
  logic [31:0]       rd;             // Read data from the bus task
  logic              er;             // Error flag from the bus task
  logic [31:0]       rnd;            // Random stimulus word

  pmcc_top #(.NPERIPH(8), .WAKE_CLKS(WAKE)) i_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .eint_pin_i(eint_pin_i),
    .periph_irq_i(periph_irq_i), .osc_ready_i(osc_ready_i),
    .flash_done_i(flash_done_i), .pll_lock_i(pll_lock_i),
    .cpu_reset_n_o(cpu_reset_n_o), .cpu_run_o(cpu_run_o),
    .osc_enable_o(osc_enable_o), .pll_enable_o(pll_enable_o),
    .pll_connect_o(pll_connect_o), .pclk_en_o(pclk_en_o),
    .periph_pwr_o(periph_pwr_o), .map_sram_o(map_sram_o),
    .hold_pins_o(hold_pins_o), .eint_irq_o(eint_irq_o));

  // Free-running clock, 10 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard: an expired ceiling is a mismatch
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      wrap_up();
    end
  end

  // Step n edges, then look once outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    // Only the bench's cycle ceiling ends a wait that never answers
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Distance in cycles between two bus clock enable pulses
  task automatic measure(output int p);
    for (int i = 0; i < 10 && pclk_en_o !== 1'b1; i++) tick(1);
    tick(1);
    p = 1;
    while (pclk_en_o !== 1'b1 && p < 10) begin
      tick(1);
      p++;
    end
  endtask

  // Expected period of the bus clock for a divider code
  function automatic int exp_per(input logic [1:0] code);
    if (code == `PMCC_DIV_FULL) return 1;
    if (code == `PMCC_DIV_HALF) return 2;
    return 4;
  endfunction

  // Print the counts and the verdict, then stop
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    rnd = $urandom(10);
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {eint_pin_i, periph_irq_i, osc_ready_i, flash_done_i} = '0;
    pll_lock_i = 1'b0;
    resetn_i = 1'b0;
    tick(5);
    `CHK({cpu_reset_n_o, osc_enable_o, map_sram_o}, 3'b010)
    `CHK({pll_enable_o, pll_connect_o}, 2'b00)
    `CHK(periph_pwr_o, 8'hff)
    resetn_i <= 1'b1;
    osc_ready_i <= 1'b1;
    tick(30);
    // Flash still busy: internal reset must hold
    `CHK(cpu_reset_n_o, 1'b0)
    flash_done_i <= 1'b1;
    for (k = 0; k < 40 && cpu_run_o !== 1'b1; k++) tick(1);
    `CHK({cpu_reset_n_o, cpu_run_o}, 2'b11)
    measure(per);
    measure(per);
    `CHK(per, 4)
    // Every divider code, full rate included
    for (k = 3; k >= 0; k--) begin
      apb(1'b1, `PMCC_OFF_DIV, 32'(k), rd, er);
      measure(per);
      measure(per);
      `CHK(per, exp_per(2'(k)))
    end
    // Random power masks and vector map selections
    for (k = 0; k < 4; k++) begin
      rnd = $urandom;
      apb(1'b1, `PMCC_OFF_PWR, {24'h0, rnd[7:0]}, rd, er);
      apb(1'b1, `PMCC_OFF_MAP, {31'h0, rnd[8]}, rd, er);
      tick(1);
      `CHK(periph_pwr_o, rnd[7:0])
      `CHK(map_sram_o, rnd[8])
    end
    apb(1'b0, 8'h40, 32'h0000_0000, rd, er);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    // Deep sleep: pin 5 feeds channel 1 (wake), pin 6 channel 2 (no wake)
    apb(1'b1, `PMCC_OFF_PINSEL, 32'h0000_0060, rd, er);
    apb(1'b1, `PMCC_OFF_ECFG, 32'h0000_02F0, rd, er);
    apb(1'b1, `PMCC_OFF_MODE, 32'h0000_0002, rd, er);
    tick(1);
    `CHK({osc_enable_o, cpu_run_o}, 2'b00)
    `CHK({hold_pins_o, periph_pwr_o, map_sram_o}, {1'b1, rnd[7:0], rnd[8]})
    osc_ready_i <= 1'b0;
    eint_pin_i <= 9'h040;
    tick(20);
    `CHK(osc_enable_o, 1'b0)
    eint_pin_i <= 9'h060;
    for (k = 0; k < 20 && osc_enable_o !== 1'b1; k++) tick(1);
    `CHK(osc_enable_o, 1'b1)
    tick(20);
    // Oscillator not yet running: execution must stay halted
    `CHK(cpu_run_o, 1'b0)
    osc_ready_i <= 1'b1;
    for (k = 0; k < 100 && cpu_run_o !== 1'b1; k++) tick(1);
    `CHK(cpu_run_o, 1'b1)
    `CHK(k >= WAKE, 1'b1)
    `CHK(eint_irq_o[2:1], 2'b11)
    apb(1'b0, `PMCC_OFF_MODE, 32'h0000_0000, rd, er);
    `CHK(rd[1:0], 2'b00)
    eint_pin_i <= 9'h000;
    apb(1'b1, `PMCC_OFF_EFLAG, 32'h0000_000F, rd, er);
    tick(1);
    `CHK(eint_irq_o, 4'h0)
    // Light sleep with the PLL running and half-rate bus clock
    apb(1'b1, `PMCC_OFF_PLL, 32'h0000_0001, rd, er);
    apb(1'b1, `PMCC_OFF_DIV, 32'h0000_0002, rd, er);
    apb(1'b1, `PMCC_OFF_MODE, 32'h0000_0001, rd, er);
    tick(20);
    `CHK({cpu_run_o, pll_enable_o}, 2'b01)
    measure(per);
    `CHK(per, 2)
    periph_irq_i <= 1'b1;
    for (k = 0; k < 20 && cpu_run_o !== 1'b1; k++) tick(1);
    `CHK(cpu_run_o, 1'b1)
    periph_irq_i <= 1'b0;
    apb(1'b0, `PMCC_OFF_MODE, 32'h0000_0000, rd, er);
    `CHK(rd[1:0], 2'b00)
    wrap_up();
  end
endmodule
